// file: common/msd_defs.svh
/*
 Constants for the memory space decoder: register offsets, field positions,
 reset values, address boundaries and timing counts.
 Assumes inclusion by bare name from the package and design files.
*/
`ifndef MSD_DEFS_SVH
`define MSD_DEFS_SVH

`define MSD_BPC_OFFSET      8'hA2
`define MSD_AUX_OFFSET      8'h8E
`define MSD_PLO_OFFSET      8'h82
`define MSD_PHI_OFFSET      8'h83
`define MSD_BPC_RESET       8'h00
`define MSD_AUX_RESET       8'h00
`define MSD_BPC_PSEL_BIT    0
`define MSD_BPC_LPE_BIT     3
`define MSD_AUX_ERD_BIT     1
`define MSD_SECTOR_BITS     7
`define MSD_PRI_SECTORS     256
`define MSD_SEC_SECTORS     16
`define MSD_PRI_TOP         16'h7FFF
`define MSD_SEC_BASE        16'hF800
`define MSD_SEC_TOP         16'hFFFF
`define MSD_BOOT_VECTOR     16'hF800
`define MSD_LOW_RAM_TOP     8'h7F
`define MSD_ON_CHIP_EXTENDED_MEMORY_TOP        16'h02FF
`define MSD_ON_CHIP_EXTENDED_MEMORY_BYTE_TOP   16'h00FF
`define MSD_ON_CHIP_EXTENDED_MEMORY_WORDS      768
`define MSD_IRAM_WORDS      256
`define MSD_ALE_DIV         6
`define MSD_ALE_DIV_W       3

`endif

// file: common/msd_pkg.sv
/*
 Types shared by the memory space decoder.
 Assumes msd_defs.svh is on the include path.
*/
`include "msd_defs.svh"

package msd_pkg;

  typedef enum logic [1:0]
  {
    MSD_ACC_DIRECT   = 2'b00,
    MSD_ACC_INDIRECT = 2'b01,
    MSD_ACC_XBYTE    = 2'b10,
    MSD_ACC_XPTR     = 2'b11
  } msd_acc_e;

  typedef enum logic [1:0]
  {
    MSD_TGT_IRAM = 2'b00,
    MSD_TGT_SFR  = 2'b01,
    MSD_TGT_ON_CHIP_EXTENDED_MEMORY = 2'b10,
    MSD_TGT_EXT  = 2'b11
  } msd_tgt_e;

  typedef enum logic [1:0]
  {
    MSD_XB_IDLE = 2'b00,
    MSD_XB_ADDR = 2'b01,
    MSD_XB_DATA = 2'b10,
    MSD_XB_DONE = 2'b11
  } msd_xb_e;

endpackage

// file: hdl/msd_memory_space_decoder.sv
/*
 Memory space decoder: program flash partition mapping, loader-partition
 gating, data space steering (internal RAM, special function registers,
 768-byte expanded RAM, external bus), dual data pointers, address latch
 strobe generation.
 Assumes a core that presents one access request per pulse on the clock
 clk_i; pins arrive asynchronously and are synchronised here.
*/
// What this block does
// - Primary 32 KB flash is 256 sectors of 128 bytes.
// - Secondary 2 KB loader partition is 16 sectors of 128 bytes.
// - Low 7 address bits pick byte, upper bits pick sector.
// - Primary partition splits into four logical pages.
// - Loader-partition enable at A2H gates secondary partition, clear by default.
// - Enable set by boot-from-zero or straps at reset release.
// - Booting from default or user boot vector sets loader-partition enable.
// - First 256 bytes of internal RAM available without configuration.
// - RAM 00H-7FH reachable by direct and indirect access.
// - At 80H-FFH indirect reaches upper RAM, direct reaches registers.
// - Disable bit clear: external moves below 300H hit expanded RAM.
// - Expanded RAM accesses drive no ports and no strobes.
// - Disable bit clear: pointer moves at 300H and above use external bus.
// - Disable bit clear: byte-register moves reach only expanded RAM 0-FFH.
// - Disable bit set: every external move uses the bus with strobes.
// - Byte-register move outputs 8-bit address multiplexed on low port.
// - Pointer move puts high byte on high port, low byte on low port.
// - Two 16-bit pointers; select bit picks first at 0, second at 1.
// - Incrementing the select register toggles the active pointer.
// - Address latch strobe runs at 1/6; one pulse skipped per external access.
`timescale 1ns/100ps
`default_nettype none
`include "msd_defs.svh"

module msd_memory_space_decoder
#(
  parameter int unsigned ALE_DIV = `MSD_ALE_DIV
)
(
  input  wire logic            clk_i,
  input  wire logic            rst_n_i,
  // Program fetch
  input  wire logic [15:0]     pc_addr_i,
  input  wire logic            pc_fetch_i,
  input  wire logic            boot_from_zero_i,
  input  wire logic            user_boot_i,
  input  wire logic [15:0]     user_boot_vector_i,
  input  wire logic            p1_0_pin_i,
  input  wire logic            p1_1_pin_i,
  input  wire logic            ext_access_strap_i,
  output logic                 prog_hit_pri_o,
  output logic                 prog_hit_sec_o,
  output logic                 prog_ext_o,
  output logic [7:0]           prog_sector_o,
  output logic [6:0]           prog_byte_o,
  output logic [1:0]           prog_page_o,
  // Register port
  input  wire logic            sfr_wr_i,
  input  wire logic            sfr_inc_i,
  input  wire logic [7:0]      sfr_addr_i,
  input  wire logic [7:0]      sfr_wdata_i,
  output logic [7:0]           sfr_rdata_o,
  // Data access
  input  wire logic            acc_req_i,
  input  wire msd_pkg::msd_acc_e acc_kind_i,
  input  wire logic            acc_we_i,
  input  wire logic [7:0]      acc_addr_i,
  input  wire logic [7:0]      acc_wdata_i,
  output logic [7:0]           acc_rdata_o,
  output logic                 acc_done_o,
  output msd_pkg::msd_tgt_e    acc_target_o,
  // External bus
  input  wire logic [7:0]      low_bus_port_i,
  output logic [7:0]           low_bus_port_o,
  output logic                 low_bus_port_oe_o,
  output logic [7:0]           high_address_port_o,
  output logic                 high_address_port_oe_o,
  output logic                 wr_n_o,
  output logic                 rd_n_o,
  output logic                 ale_o
);
  import msd_pkg::*;

  logic [7:0]  bpc_ff;
  logic [7:0]  aux_ff;
  logic [15:0] first_data_pointer_ff;
  logic [15:0] second_data_pointer_ff;
  logic [2:0]  p10_sync_ff;
  logic [2:0]  p11_sync_ff;
  logic [2:0]  ea_sync_ff;
  logic        rst_seen_ff;
  logic [7:0]  iram_mem [0:`MSD_IRAM_WORDS-1];
  logic [7:0]  on_chip_extended_memory_mem [0:`MSD_ON_CHIP_EXTENDED_MEMORY_WORDS-1];
  msd_xb_e     xb_state_ff;
  msd_xb_e     nxt_xb_state;
  logic [15:0] xb_addr_ff;
  logic [7:0]  xb_wdata_ff;
  logic        xb_we_ff;
  logic [2:0]  ale_cnt_ff;
  logic        ale_skip_ff;
  logic        psel;
  logic        erd;
  logic [15:0] active_data_pointer;
  logic [15:0] acc_full;
  msd_tgt_e    tgt;
  logic [7:0]  sfr_rd;
  logic [7:0]  bpc_inc;

  // Active pointer select
  assign psel = bpc_ff[`MSD_BPC_PSEL_BIT];
  assign erd  = aux_ff[`MSD_AUX_ERD_BIT];
  assign active_data_pointer = psel ? second_data_pointer_ff : first_data_pointer_ff;
  assign bpc_inc = bpc_ff + 8'h01;

  // Data space routing
  function automatic msd_tgt_e route(input msd_acc_e kind, input logic [15:0] addr,
                                     input logic erdis);
    route = MSD_TGT_IRAM;
    case (kind)
      MSD_ACC_DIRECT:
        route = (addr[7:0] > `MSD_LOW_RAM_TOP) ? MSD_TGT_SFR : MSD_TGT_IRAM;
      MSD_ACC_INDIRECT:
        route = MSD_TGT_IRAM;
      MSD_ACC_XBYTE:
        route = erdis ? MSD_TGT_EXT : MSD_TGT_ON_CHIP_EXTENDED_MEMORY;
      MSD_ACC_XPTR:
        route = (erdis || addr > `MSD_ON_CHIP_EXTENDED_MEMORY_TOP) ? MSD_TGT_EXT : MSD_TGT_ON_CHIP_EXTENDED_MEMORY;
      default:
        route = MSD_TGT_IRAM;
    endcase
  endfunction

  assign acc_full = (acc_kind_i == MSD_ACC_XPTR) ? active_data_pointer : {8'h00, acc_addr_i};
  assign tgt = route(acc_kind_i, acc_full, erd);

  // Pin synchronisers; run through reset so straps are valid at release
  always_ff @(posedge clk_i)
  begin
    p10_sync_ff <= {p10_sync_ff[1:0], p1_0_pin_i};
    p11_sync_ff <= {p11_sync_ff[1:0], p1_1_pin_i};
    ea_sync_ff  <= {ea_sync_ff[1:0], ext_access_strap_i};
  end

  // Boot/pointer control register
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      bpc_ff      <= `MSD_BPC_RESET;
      rst_seen_ff <= 1'b0;
    end
    else
    begin
      rst_seen_ff <= 1'b1;
      if (sfr_inc_i && sfr_addr_i == `MSD_BPC_OFFSET)
        bpc_ff <= bpc_inc;
      else if (sfr_wr_i && sfr_addr_i == `MSD_BPC_OFFSET)
        bpc_ff <= sfr_wdata_i;
      if (!rst_seen_ff && boot_from_zero_i)
        bpc_ff[`MSD_BPC_LPE_BIT] <= 1'b1;
      if (!rst_seen_ff && p10_sync_ff[2] == 1'b0 && p11_sync_ff[2] == 1'b0
          && p10_sync_ff[1] == 1'b0 && p11_sync_ff[1] == 1'b0
          && ea_sync_ff[2] && ea_sync_ff[1])
        bpc_ff[`MSD_BPC_LPE_BIT] <= 1'b1;
      if (pc_fetch_i && (pc_addr_i == `MSD_BOOT_VECTOR
          || (user_boot_i && pc_addr_i == user_boot_vector_i)))
        bpc_ff[`MSD_BPC_LPE_BIT] <= 1'b1;
    end
  end

  // Auxiliary control register
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      aux_ff <= `MSD_AUX_RESET;
    else if (sfr_wr_i && sfr_addr_i == `MSD_AUX_OFFSET)
      aux_ff <= sfr_wdata_i;
  end

  // Dual data pointers
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      first_data_pointer_ff <= 16'h0000;
      second_data_pointer_ff <= 16'h0000;
    end
    else if (sfr_wr_i && sfr_addr_i == `MSD_PLO_OFFSET)
    begin
      if (psel)
        second_data_pointer_ff[7:0] <= sfr_wdata_i;
      else
        first_data_pointer_ff[7:0] <= sfr_wdata_i;
    end
    else if (sfr_wr_i && sfr_addr_i == `MSD_PHI_OFFSET)
    begin
      if (psel)
        second_data_pointer_ff[15:8] <= sfr_wdata_i;
      else
        first_data_pointer_ff[15:8] <= sfr_wdata_i;
    end
  end

  always_comb
  begin
    case (sfr_addr_i)
      `MSD_BPC_OFFSET: sfr_rd = bpc_ff;
      `MSD_AUX_OFFSET: sfr_rd = aux_ff;
      `MSD_PLO_OFFSET: sfr_rd = active_data_pointer[7:0];
      `MSD_PHI_OFFSET: sfr_rd = active_data_pointer[15:8];
      default:         sfr_rd = 8'h00;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      sfr_rdata_o <= 8'h00;
    else
      sfr_rdata_o <= sfr_rd;
  end

  // Program address mapping
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      prog_hit_pri_o <= 1'b0;
      prog_hit_sec_o <= 1'b0;
      prog_ext_o     <= 1'b0;
      prog_sector_o  <= 8'h00;
      prog_byte_o    <= 7'h00;
      prog_page_o    <= 2'h0;
    end
    else
    begin
      prog_byte_o    <= pc_addr_i[`MSD_SECTOR_BITS-1:0];
      prog_sector_o  <= pc_addr_i[14:7];
      prog_page_o    <= pc_addr_i[14:13];
      prog_hit_pri_o <= pc_fetch_i && pc_addr_i <= `MSD_PRI_TOP;
      prog_hit_sec_o <= pc_fetch_i && pc_addr_i >= `MSD_SEC_BASE
                        && bpc_ff[`MSD_BPC_LPE_BIT];
      prog_ext_o     <= pc_fetch_i && pc_addr_i > `MSD_PRI_TOP
                        && !(pc_addr_i >= `MSD_SEC_BASE && bpc_ff[`MSD_BPC_LPE_BIT]);
      if (pc_addr_i >= `MSD_SEC_BASE)
        prog_sector_o <= {4'h0, pc_addr_i[10:7]};
    end
  end

  // Internal and expanded RAM
  always_ff @(posedge clk_i)
  begin
    if (acc_req_i && acc_we_i && tgt == MSD_TGT_IRAM)
      iram_mem[acc_addr_i] <= acc_wdata_i;
    if (acc_req_i && acc_we_i && tgt == MSD_TGT_ON_CHIP_EXTENDED_MEMORY)
      on_chip_extended_memory_mem[acc_full[9:0]] <= acc_wdata_i;
  end

  // External bus cycle sequencer
  always_comb
  begin
    nxt_xb_state = xb_state_ff;
    case (xb_state_ff)
      MSD_XB_IDLE: if (acc_req_i && tgt == MSD_TGT_EXT) nxt_xb_state = MSD_XB_ADDR;
      MSD_XB_ADDR: nxt_xb_state = MSD_XB_DATA;
      MSD_XB_DATA: nxt_xb_state = MSD_XB_DONE;
      MSD_XB_DONE: nxt_xb_state = MSD_XB_IDLE;
      default:     nxt_xb_state = MSD_XB_IDLE;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      xb_state_ff <= MSD_XB_IDLE;
      xb_addr_ff  <= 16'h0000;
      xb_wdata_ff <= 8'h00;
      xb_we_ff    <= 1'b0;
    end
    else
    begin
      xb_state_ff <= nxt_xb_state;
      if (xb_state_ff == MSD_XB_IDLE && acc_req_i && tgt == MSD_TGT_EXT)
      begin
        xb_addr_ff  <= acc_full;
        xb_wdata_ff <= acc_wdata_i;
        xb_we_ff    <= acc_we_i;
      end
    end
  end

  // Bus pins; only driven during external cycles
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      low_bus_port_o         <= 8'h00;
      low_bus_port_oe_o      <= 1'b0;
      high_address_port_o    <= 8'h00;
      high_address_port_oe_o <= 1'b0;
      wr_n_o                 <= 1'b1;
      rd_n_o                 <= 1'b1;
    end
    else
    begin
      low_bus_port_oe_o      <= 1'b0;
      high_address_port_oe_o <= 1'b0;
      wr_n_o                 <= 1'b1;
      rd_n_o                 <= 1'b1;
      case (nxt_xb_state)
        MSD_XB_ADDR:
        begin
          low_bus_port_o         <= xb_state_ff == MSD_XB_IDLE ? acc_full[7:0] : xb_addr_ff[7:0];
          low_bus_port_oe_o      <= 1'b1;
          high_address_port_o    <= acc_full[15:8];
          high_address_port_oe_o <= acc_kind_i == MSD_ACC_XPTR;
        end
        MSD_XB_DATA:
        begin
          low_bus_port_o         <= xb_wdata_ff;
          low_bus_port_oe_o      <= xb_we_ff;
          high_address_port_oe_o <= high_address_port_oe_o;
          wr_n_o                 <= !xb_we_ff;
          rd_n_o                 <= xb_we_ff;
        end
        default:
        begin
          low_bus_port_o <= low_bus_port_o;
        end
      endcase
    end
  end

  // Access answers
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      acc_done_o   <= 1'b0;
      acc_rdata_o  <= 8'h00;
      acc_target_o <= MSD_TGT_IRAM;
    end
    else
    begin
      acc_done_o <= 1'b0;
      if (xb_state_ff == MSD_XB_DATA)
      begin
        acc_done_o  <= 1'b1;
        acc_rdata_o <= low_bus_port_i;
      end
      else if (acc_req_i && tgt != MSD_TGT_EXT && xb_state_ff == MSD_XB_IDLE)
      begin
        acc_done_o   <= 1'b1;
        acc_target_o <= tgt;
        case (tgt)
          MSD_TGT_IRAM: acc_rdata_o <= iram_mem[acc_addr_i];
          MSD_TGT_ON_CHIP_EXTENDED_MEMORY: acc_rdata_o <= on_chip_extended_memory_mem[acc_full[9:0]];
          default:      acc_rdata_o <= 8'h00;
        endcase
      end
      else if (acc_req_i && xb_state_ff == MSD_XB_IDLE)
        acc_target_o <= tgt;
    end
  end

  // Address latch strobe, one pulse skipped per external access
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      ale_cnt_ff  <= 3'h0;
      ale_skip_ff <= 1'b0;
      ale_o       <= 1'b0;
    end
    else
    begin
      ale_cnt_ff <= (ale_cnt_ff == 3'(ALE_DIV - 1)) ? 3'h0 : ale_cnt_ff + 3'h1;
      ale_o <= 1'b0;
      if (ale_cnt_ff == 3'h0)
      begin
        if (ale_skip_ff)
          ale_skip_ff <= 1'b0;
        else
          ale_o <= 1'b1;
      end
      // New access wins over a same-cycle consume
      if (xb_state_ff == MSD_XB_IDLE && acc_req_i && tgt == MSD_TGT_EXT)
        ale_skip_ff <= 1'b1;
    end
  end

endmodule
`default_nettype wire

// file: dv/msd_checker.sv
/*
 Port-level assertions for the memory space decoder.
 Assumes the ports and timing of msd_memory_space_decoder, one clock domain.
*/
`timescale 1ns/100ps
`default_nettype none

module msd_checker
  import msd_pkg::*;
(
  input wire logic       clk_i,
  input wire logic       rst_n_i,
  input wire logic [15:0] pc_addr_i,
  input wire logic       pc_fetch_i,
  input wire logic       sfr_wr_i,
  input wire logic       sfr_inc_i,
  input wire logic [7:0] sfr_addr_i,
  input wire logic [7:0] sfr_rdata_o,
  input wire logic       acc_req_i,
  input wire msd_acc_e   acc_kind_i,
  input wire logic [7:0] acc_addr_i,
  input wire logic       acc_done_o,
  input wire msd_tgt_e   acc_target_o,
  input wire logic [6:0] prog_byte_o,
  input wire logic [1:0] prog_page_o,
  input wire logic       low_bus_port_oe_o,
  input wire logic       high_address_port_oe_o,
  input wire logic       wr_n_o,
  input wire logic       rd_n_o,
  input wire logic       ale_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);

  sequence s_inc;
    sfr_addr_i == 8'hA2 ##1 sfr_inc_i && sfr_addr_i == 8'hA2
      ##1 sfr_addr_i == 8'hA2 && !sfr_inc_i && !sfr_wr_i;
  endsequence
  sequence s_xbyte_addr;
    acc_req_i && acc_kind_i == MSD_ACC_XBYTE ##1 low_bus_port_oe_o;
  endsequence

  property p_psel;
    s_inc |=> sfr_rdata_o[0] != $past(sfr_rdata_o[0], 2);
  endproperty
  property p_byte_hi;
    s_xbyte_addr |-> !high_address_port_oe_o;
  endproperty
  property p_ale_gap;
    ale_o |=> !ale_o [*5];
  endproperty
  property p_ale_run;
    !acc_req_i ##1 ale_o && !acc_req_i ##1 !acc_req_i [*5] |=> ale_o;
  endproperty
  property p_ext_strobe;
    $fell(rd_n_o) || $fell(wr_n_o) |=> acc_done_o && acc_target_o == MSD_TGT_EXT;
  endproperty
  property p_on_chip_extended_memory_quiet;
    acc_done_o && acc_target_o == MSD_TGT_ON_CHIP_EXTENDED_MEMORY
      |-> rd_n_o && wr_n_o && !low_bus_port_oe_o && !high_address_port_oe_o;
  endproperty
  property p_direct;
    acc_req_i && acc_kind_i == MSD_ACC_DIRECT |=> acc_done_o
      && acc_target_o == ($past(acc_addr_i[7]) ? MSD_TGT_SFR : MSD_TGT_IRAM);
  endproperty
  property p_indirect;
    acc_req_i && acc_kind_i == MSD_ACC_INDIRECT |=> acc_done_o && acc_target_o == MSD_TGT_IRAM;
  endproperty
  property p_prog;
    pc_fetch_i |=> prog_byte_o == $past(pc_addr_i[6:0])
      && prog_page_o == $past(pc_addr_i[14:13]);
  endproperty

  a_psel: assert property (p_psel) else $error("select bit did not toggle");
  a_byte_hi: assert property (p_byte_hi) else $error("high port driven on byte move");
  a_ale_gap: assert property (p_ale_gap) else $error("strobe pulses too close");
  a_ale_run: assert property (p_ale_run) else $error("strobe pulse missing");
  a_ext_strobe: assert property (p_ext_strobe) else $error("bus cycle not ended");
  a_on_chip_extended_memory_quiet: assert property (p_on_chip_extended_memory_quiet) else $error("bus moved on ram access");
  a_direct: assert property (p_direct) else $error("direct access misrouted");
  a_indirect: assert property (p_indirect) else $error("indirect access misrouted");
  a_prog: assert property (p_prog) else $error("program fields wrong");
endmodule

bind msd_memory_space_decoder msd_checker u_chk (.clk_i(clk_i), .rst_n_i(rst_n_i),
  .pc_addr_i(pc_addr_i), .pc_fetch_i(pc_fetch_i), .sfr_wr_i(sfr_wr_i),
  .sfr_inc_i(sfr_inc_i), .sfr_addr_i(sfr_addr_i), .sfr_rdata_o(sfr_rdata_o),
  .acc_req_i(acc_req_i), .acc_kind_i(acc_kind_i), .acc_addr_i(acc_addr_i),
  .acc_done_o(acc_done_o), .acc_target_o(acc_target_o), .prog_byte_o(prog_byte_o),
  .prog_page_o(prog_page_o), .low_bus_port_oe_o(low_bus_port_oe_o),
  .high_address_port_oe_o(high_address_port_oe_o), .wr_n_o(wr_n_o),
  .rd_n_o(rd_n_o), .ale_o(ale_o));

`default_nettype wire

// file: dv/msd_ext_mem.sv
/*
 External data memory on the multiplexed bus, keyed by the low address byte.
 Assumes address on the low port while both strobes are high.
*/
`timescale 1ns/100ps
`default_nettype none

module msd_ext_mem
(
  input wire logic       clk_i,
  input wire logic [7:0] low_bus_port_o,
  input wire logic       low_bus_port_oe_o,
  input wire logic       rd_n_o,
  input wire logic       wr_n_o,
  output logic [7:0]     bus_o
);
  logic [7:0] mem_ff [256];
  logic [7:0] adr_ff = 8'h00;
  logic [7:0] last_ff = 8'h00;

  // Released bus shows no stale value
  assign bus_o = rd_n_o ? ~last_ff : mem_ff[adr_ff];

  always_ff @(posedge clk_i)
  begin
    last_ff <= bus_o;
    if (low_bus_port_oe_o && rd_n_o && wr_n_o) adr_ff <= low_bus_port_o;
    if (!wr_n_o) mem_ff[adr_ff] <= low_bus_port_o;
  end
endmodule

`default_nettype wire

// file: dv/test_memory_space_decoder.sv
/*
 Self-checking bench for the memory space decoder.
 Assumes the external memory model on the multiplexed bus.
*/
`timescale 1ns/100ps
`default_nettype none

module test_memory_space_decoder;
  import msd_pkg::*;
  logic clk_i = 1'b0, rst_n_i = 1'b0, pc_fetch_i = 1'b0, bfz = 1'b0, ub = 1'b0;
  logic p10 = 1'b1, p11 = 1'b1, strap = 1'b1, sfr_wr_i = 1'b0, sfr_inc_i = 1'b0;
  logic acc_req_i = 1'b0, acc_we_i = 1'b0, sb, pri, sec, done, lo_oe, hi_oe, wr_n, rd_n;
  logic pext;
  logic [15:0] pc_addr_i = 16'h0000, ubv = 16'h1000, la;
  logic [7:0] sfr_addr_i = 8'h00, sfr_wdata_i = 8'h00, acc_addr_i = 8'h00;
  logic [7:0] acc_wdata_i = 8'h00, d, rd, bus_in, lo, hi, sfr_rd, acc_rd, sector;
  logic [6:0] pbyte;
  logic [1:0] page;
  msd_acc_e acc_kind_i = MSD_ACC_DIRECT;
  msd_tgt_e tgt, target;
  int error_cnt = 0, check_count = 0;

  always #2 clk_i = ~clk_i;

  msd_memory_space_decoder dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .pc_addr_i(pc_addr_i),
    .pc_fetch_i(pc_fetch_i), .boot_from_zero_i(bfz), .user_boot_i(ub),
    .user_boot_vector_i(ubv), .p1_0_pin_i(p10), .p1_1_pin_i(p11),
    .ext_access_strap_i(strap), .prog_hit_pri_o(pri), .prog_hit_sec_o(sec),
    .prog_ext_o(pext), .prog_sector_o(sector), .prog_byte_o(pbyte), .prog_page_o(page),
    .sfr_wr_i(sfr_wr_i), .sfr_inc_i(sfr_inc_i), .sfr_addr_i(sfr_addr_i),
    .sfr_wdata_i(sfr_wdata_i), .sfr_rdata_o(sfr_rd), .acc_req_i(acc_req_i),
    .acc_kind_i(acc_kind_i), .acc_we_i(acc_we_i), .acc_addr_i(acc_addr_i),
    .acc_wdata_i(acc_wdata_i), .acc_rdata_o(acc_rd), .acc_done_o(done),
    .acc_target_o(target), .low_bus_port_i(bus_in), .low_bus_port_o(lo),
    .low_bus_port_oe_o(lo_oe), .high_address_port_o(hi), .high_address_port_oe_o(hi_oe),
    .wr_n_o(wr_n), .rd_n_o(rd_n), .ale_o());
  msd_ext_mem u_mem (.clk_i(clk_i), .low_bus_port_o(lo), .low_bus_port_oe_o(lo_oe),
    .rd_n_o(rd_n), .wr_n_o(wr_n), .bus_o(bus_in));

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic step();
    @(posedge clk_i);
    #1;
  endtask
  task automatic sfr_w(input logic [7:0] a, input logic [7:0] v);
    sfr_addr_i = a;
    sfr_wdata_i = v;
    sfr_wr_i = 1'b1;
    step();
    sfr_wr_i = 1'b0;
    step();
  endtask
  task automatic sfr_r(input logic [7:0] a);
    sfr_addr_i = a;
    step();
    d = sfr_rd;
  endtask
  task automatic inc();
    sfr_inc_i = 1'b1;
    step();
    sfr_inc_i = 1'b0;
  endtask
  task automatic fetch(input logic [15:0] a);
    step();
    pc_addr_i = a;
    pc_fetch_i = 1'b1;
    step();
    pc_fetch_i = 1'b0;
  endtask
  task automatic acc(input msd_acc_e k, input logic w, input logic [7:0] a,
                     input logic [7:0] v);
    int i;
    acc_kind_i = k;
    acc_we_i = w;
    acc_addr_i = a;
    acc_wdata_i = v;
    acc_req_i = 1'b1;
    sb = 1'b0;
    step();
    acc_req_i = 1'b0;
    for (i = 0; i < 8; i++)
    begin
      if (lo_oe && rd_n && wr_n) la = {hi, lo};
      if (!rd_n || !wr_n || lo_oe || hi_oe) sb = 1'b1;
      if (done === 1'b1) break;
      step();
    end
    chk(16'(i < 8), 16'h0001);
    rd = acc_rd;
    tgt = target;
    // Sequencer passes one more state before it takes a new request
    step();
  endtask

  task automatic t_reset();
    sfr_r(8'hA2);
    chk(d, 8'h00);
    sfr_r(8'h8E);
    chk(d, 8'h00);
    chk({rd_n, wr_n}, 2'b11);
    $display("t_reset done");
  endtask
  task automatic t_prog();
    fetch(16'h7F85);
    chk({pri, sec}, 2'b10);
    chk(sector, 8'hFF);
    chk(pbyte, 7'h05);
    chk(page, 2'h3);
    fetch(16'hF880);
    chk(sec, 1'b0);
    chk(pext, 1'b1);
    fetch(16'hF800);
    sfr_r(8'hA2);
    chk(d[3], 1'b1);
    fetch(16'hF880);
    chk({sec, sector, pbyte}, {1'b1, 8'h01, 7'h00});
    $display("t_prog done");
  endtask
  task automatic t_int();
    acc(MSD_ACC_DIRECT, 1'b1, 8'h10, 8'h5A);
    chk(tgt, MSD_TGT_IRAM);
    acc(MSD_ACC_INDIRECT, 1'b0, 8'h10, 8'h00);
    chk(rd, 8'h5A);
    acc(MSD_ACC_INDIRECT, 1'b1, 8'h90, 8'h33);
    acc(MSD_ACC_DIRECT, 1'b0, 8'h90, 8'h00);
    chk(tgt, MSD_TGT_SFR);
    acc(MSD_ACC_INDIRECT, 1'b0, 8'h90, 8'h00);
    chk({tgt, rd}, {MSD_TGT_IRAM, 8'h33});
    $display("t_int done");
  endtask
  task automatic t_on_chip_extended_memory();
    sfr_w(8'h82, 8'hA0);
    sfr_w(8'h83, 8'h00);
    acc(MSD_ACC_XPTR, 1'b1, 8'h00, 8'hC3);
    chk({tgt, sb}, {MSD_TGT_ON_CHIP_EXTENDED_MEMORY, 1'b0});
    acc(MSD_ACC_XBYTE, 1'b0, 8'hA0, 8'h00);
    chk({tgt, sb, rd}, {MSD_TGT_ON_CHIP_EXTENDED_MEMORY, 1'b0, 8'hC3});
    sfr_w(8'h83, 8'h03);
    sfr_w(8'h82, 8'h00);
    acc(MSD_ACC_XPTR, 1'b1, 8'h00, 8'h96);
    chk({tgt, sb}, {MSD_TGT_EXT, 1'b1});
    chk(la, 16'h0300);
    acc(MSD_ACC_XPTR, 1'b0, 8'h00, 8'h00);
    chk(rd, 8'h96);
    $display("t_on_chip_extended_memory done");
  endtask
  task automatic t_xdis();
    sfr_w(8'h8E, 8'h02);
    acc(MSD_ACC_XBYTE, 1'b1, 8'h45, 8'h77);
    chk({tgt, sb, la[7:0]}, {MSD_TGT_EXT, 1'b1, 8'h45});
    acc(MSD_ACC_XBYTE, 1'b0, 8'h45, 8'h00);
    chk(rd, 8'h77);
    sfr_w(8'h83, 8'h00);
    acc(MSD_ACC_XPTR, 1'b0, 8'h00, 8'h00);
    chk({tgt, sb}, {MSD_TGT_EXT, 1'b1});
    sfr_w(8'h8E, 8'h00);
    $display("t_xdis done");
  endtask
  task automatic t_dual();
    sfr_w(8'h82, 8'h34);
    sfr_w(8'h83, 8'h12);
    sfr_r(8'hA2);
    inc();
    sfr_r(8'hA2);
    chk(d[0], 1'b1);
    sfr_w(8'h82, 8'h78);
    sfr_r(8'h82);
    chk(d, 8'h78);
    sfr_r(8'hA2);
    inc();
    sfr_r(8'h82);
    chk(d, 8'h34);
    sfr_r(8'h83);
    chk(d, 8'h12);
    $display("t_dual done");
  endtask
  task automatic t_boot();
    rst_n_i = 1'b0;
    p10 = 1'b0;
    p11 = 1'b0;
    repeat (4) step();
    rst_n_i = 1'b1;
    sfr_r(8'hA2);
    sfr_r(8'hA2);
    chk(d, 8'h08);
    rst_n_i = 1'b0;
    p10 = 1'b1;
    p11 = 1'b1;
    bfz = 1'b1;
    repeat (4) step();
    rst_n_i = 1'b1;
    sfr_r(8'hA2);
    sfr_r(8'hA2);
    chk(d, 8'h08);
    bfz = 1'b0;
    $display("t_boot done");
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  initial
  begin
    repeat (16) @(posedge clk_i);
    #1;
    rst_n_i = 1'b1;
    t_reset();
    t_prog();
    t_int();
    t_on_chip_extended_memory();
    t_xdis();
    t_dual();
    t_boot();
    results();
  end
  initial
  begin
    #40000;
    error_cnt++;
    results();
  end
endmodule

`default_nettype wire
